// ### rtl/amp_gain_defines.vh
`ifndef AMP_GAIN_DEFINES_VH
`define AMP_GAIN_DEFINES_VH

// ****************************************************************
// Register addresses
// ****************************************************************
`define ADDR_W                 8
`define DATA_W                 16
`define ADDR_OFFSET_CTRL       8'h01
`define ADDR_GAIN_STATUS       8'h02
`define ADDR_GAIN_MODE         8'hc4
`define ADDR_ODD_GAIN_SELECT   8'hd9

// ****************************************************************
// Field positions
// ****************************************************************
`define ADD_OFFSET_BIT         0
`define IND_ENABLE_BIT         15
`define GLOBAL_GAIN_LSB        0
`define GLOBAL_GAIN_MSB        1
`define STAT_RESERVED_BIT      0
`define STAT_ENABLE_BIT        1
`define STAT_OFFSET_BIT        2

// ****************************************************************
// Reset values
// ****************************************************************
`define GAIN_SELECT_RESET      16'h0000
`define GAIN_MODE_RESET        16'h0000
`define OFFSET_CTRL_RESET      1'b0

// ****************************************************************
// Gain codes and their values in dB
// ****************************************************************
`define GAIN_CODE_18DB         2'h0
`define GAIN_CODE_24DB         2'h1
`define GAIN_CODE_12DB         2'h2
`define GAIN_CODE_RESERVED     2'h3
`define GAIN_DB_W              5
`define GAIN_DB_18             5'h12
`define GAIN_DB_24             5'h18
`define GAIN_DB_12             5'h0c
`define GAIN_DB_NONE           5'h00

`endif

// ### rtl/gain_field_bank.v
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// One 16-bit bank of 2-bit gain fields
// ****************************************************************
module gain_field_bank #(
  parameter WIDTH = 16
) (
  input  wire             mclk,
  input  wire             rst,
  input  wire             wr_en,
  input  wire [WIDTH-1:0] wr_data,
  output reg  [WIDTH-1:0] fields_q
);

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      fields_q <= {WIDTH{1'b0}};
    end else if (wr_en) begin
      fields_q <= wr_data;
    end
  end

endmodule // gain_field_bank

`default_nettype wire

// ### rtl/amp_gain_select_regs.v
// Notes on behaviour
// - Eight 2-bit odd-channel gain fields, reset zero.
// - Codes: 00=18dB, 01=24dB, 10=12dB, 11 reserved.
// - Per-channel fields apply only while enable set.
// - Writes reach odd channels only with offset set.
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "amp_gain_defines.vh"

module amp_gain_select_regs #(
  parameter NUM_CH = 16
) (
  input  wire                             mclk,
  input  wire                             rst,
  input  wire [`ADDR_W-1:0]               addr,
  input  wire [`DATA_W-1:0]               wdata,
  input  wire                             wr,
  input  wire                             rd,
  output reg  [`DATA_W-1:0]               rdata_q,
  output reg  [2*NUM_CH-1:0]              amp_gain_code_q,
  output reg  [`GAIN_DB_W*NUM_CH-1:0]     amp_gain_db_q,
  output reg                              per_channel_gain_enable_q,
  output reg                              add_offset_q,
  output reg                              reserved_code_seen_q
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Reserved code maps to zero dB so that it never looks like a gain.
  function [`GAIN_DB_W-1:0] code_to_db;
    input [1:0] code;
    begin
      case (code)
        `GAIN_CODE_18DB: code_to_db = `GAIN_DB_18;
        `GAIN_CODE_24DB: code_to_db = `GAIN_DB_24;
        `GAIN_CODE_12DB: code_to_db = `GAIN_DB_12;
        default:         code_to_db = `GAIN_DB_NONE;
      endcase
    end
  endfunction

  function has_reserved;
    input [`DATA_W-1:0] word;
    integer k;
    begin
      has_reserved = 1'b0;
      for (k = 0; k < `DATA_W/2; k = k + 1) begin
        if (word[2*k +: 2] == `GAIN_CODE_RESERVED) begin
          has_reserved = 1'b1;
        end
      end
    end
  endfunction

  // Both banks share one layout, so the pair of channel ch sits at
  // twice its rank within its bank, for odd and even channels alike.
  function [1:0] field_at;
    input [`DATA_W-1:0] word;
    input integer       ch;
    begin
      field_at = word[2*(ch/2) +: 2];
    end
  endfunction

  // Status image: the flag beside mirrors of both control bits, so
  // one read tells software whether a field write would take effect.
  function [`DATA_W-1:0] status_word;
    input flag;
    input enable;
    input offset;
    begin
      status_word                     = {`DATA_W{1'b0}};
      status_word[`STAT_RESERVED_BIT] = flag;
      status_word[`STAT_ENABLE_BIT]   = enable;
      status_word[`STAT_OFFSET_BIT]   = offset;
    end
  endfunction

  // Mode image: only the enable bit and the global code are kept;
  // every other bit of the mode word reads back as zero.
  function [`DATA_W-1:0] mode_word;
    input       enable;
    input [1:0] glob_code;
    begin
      mode_word = {`DATA_W{1'b0}};
      mode_word[`IND_ENABLE_BIT] = enable;
      mode_word[`GLOBAL_GAIN_MSB:`GLOBAL_GAIN_LSB] = glob_code;
    end
  endfunction

  // ****************************************************************
  // Address decode
  // ****************************************************************
  wire hit_offset = (addr == `ADDR_OFFSET_CTRL);
  wire hit_status = (addr == `ADDR_GAIN_STATUS);
  wire hit_mode   = (addr == `ADDR_GAIN_MODE);
  wire hit_select = (addr == `ADDR_ODD_GAIN_SELECT);

  // Routing of the shared gain-select address between the two banks.
  wire wr_odd_bank  = wr & hit_select & add_offset_q;
  wire wr_even_bank = wr & hit_select & ~add_offset_q;

  // ****************************************************************
  // Gain field banks
  // ****************************************************************
  wire [`DATA_W-1:0] odd_fields;
  wire [`DATA_W-1:0] even_fields;

  // Odd bank: channel 15 in bits 15:14 down to channel 1 in 1:0.
  gain_field_bank #(
    .WIDTH  (`DATA_W)
  ) u_odd_bank (
    .mclk     (mclk),
    .rst      (rst),
    .wr_en    (wr_odd_bank),
    .wr_data  (wdata),
    .fields_q (odd_fields)
  );

  // Even bank: same layout, channel 14 down to channel 0.
  gain_field_bank #(
    .WIDTH  (`DATA_W)
  ) u_even_bank (
    .mclk     (mclk),
    .rst      (rst),
    .wr_en    (wr_even_bank),
    .wr_data  (wdata),
    .fields_q (even_fields)
  );

  // ****************************************************************
  // Control registers
  // ****************************************************************
  // The mode word's reset image is kept whole, so that every field of
  // it takes its reset value from one place.
  localparam [`DATA_W-1:0] MODE_RESET = `GAIN_MODE_RESET;

  reg       add_offset_d;
  reg       per_channel_gain_enable_d;
  reg [1:0] global_gain_q;
  reg [1:0] global_gain_d;

  // The offset bit picks the bank that the shared address reaches; a
  // write that changes it lands one edge before the next bank access.
  always @* begin
    add_offset_d = add_offset_q;
    if (wr && hit_offset) begin
      add_offset_d = wdata[`ADD_OFFSET_BIT];
    end
  end

  always @* begin
    per_channel_gain_enable_d = per_channel_gain_enable_q;
    global_gain_d             = global_gain_q;
    if (wr && hit_mode) begin
      per_channel_gain_enable_d = wdata[`IND_ENABLE_BIT];
      global_gain_d = wdata[`GLOBAL_GAIN_MSB:`GLOBAL_GAIN_LSB];
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      add_offset_q <= `OFFSET_CTRL_RESET;
    end else begin
      add_offset_q <= add_offset_d;
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      per_channel_gain_enable_q <= MODE_RESET[`IND_ENABLE_BIT];
      global_gain_q <= MODE_RESET[`GLOBAL_GAIN_MSB:`GLOBAL_GAIN_LSB];
    end else begin
      per_channel_gain_enable_q <= per_channel_gain_enable_d;
      global_gain_q             <= global_gain_d;
    end
  end

  // ****************************************************************
  // Reserved-code flag
  // ****************************************************************
  // A reserved code written in the same cycle as a clear still sets
  // the flag, so no reserved code written to either bank goes unnoticed.
  wire reserved_write = (wr_odd_bank | wr_even_bank) & has_reserved(wdata);
  wire reserved_clear = wr & hit_status & wdata[`STAT_RESERVED_BIT];
  reg  reserved_code_seen_d;

  always @* begin
    reserved_code_seen_d = reserved_code_seen_q;
    if (reserved_write) begin
      reserved_code_seen_d = 1'b1;
    end else if (reserved_clear) begin
      reserved_code_seen_d = 1'b0;
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      reserved_code_seen_q <= 1'b0;
    end else begin
      reserved_code_seen_q <= reserved_code_seen_d;
    end
  end

  // ****************************************************************
  // Applied gain per channel
  // ****************************************************************
  // A channel whose selected code is reserved keeps its last good
  // gain rather than moving the amplifier to an undefined setting.
  reg [2*NUM_CH-1:0]          code_d;
  reg [`GAIN_DB_W*NUM_CH-1:0] db_d;
  reg [1:0]                   pick;
  integer                     c;
  integer                     n;

  // While per-channel gain is enabled, odd channels draw from the odd bank and even ones
  // from the even bank, else all take the global code; pick is the code that the channel would move to.
  always @* begin
    code_d = amp_gain_code_q;
    pick   = 2'h0;
    for (c = 0; c < NUM_CH; c = c + 1) begin
      if (per_channel_gain_enable_q) begin
        if (c % 2 == 1) begin
          pick = field_at(odd_fields, c);
        end else begin
          pick = field_at(even_fields, c);
        end
      end else begin
        pick = global_gain_q;
      end
      if (pick != `GAIN_CODE_RESERVED) begin
        code_d[2*c +: 2] = pick;
      end
    end
  end

  // The dB view is derived from the next code and never kept apart
  // from it, so the two outputs cannot disagree for even one cycle.
  always @* begin
    db_d = {`GAIN_DB_W*NUM_CH{1'b0}};
    for (n = 0; n < NUM_CH; n = n + 1) begin
      db_d[`GAIN_DB_W*n +: `GAIN_DB_W] = code_to_db(code_d[2*n +: 2]);
    end
  end

  // Both applied views load on the same edge, so the amplifier never
  // sees a code and a dB figure that come from different writes.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      amp_gain_code_q <= {NUM_CH{`GAIN_CODE_18DB}};
    end else begin
      amp_gain_code_q <= code_d;
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      amp_gain_db_q <= {NUM_CH{`GAIN_DB_18}};
    end else begin
      amp_gain_db_q <= db_d;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Read data stand for exactly one cycle after the strobe; zero
  // otherwise, and zero for any unmapped address.
  reg [`DATA_W-1:0] rdata_d;

  always @* begin
    rdata_d = {`DATA_W{1'b0}};
    if (rd) begin
      if (hit_offset) begin
        rdata_d[`ADD_OFFSET_BIT] = add_offset_q;
      end else if (hit_status) begin
        rdata_d = status_word(reserved_code_seen_q,
                              per_channel_gain_enable_q, add_offset_q);
      end else if (hit_mode) begin
        rdata_d = mode_word(per_channel_gain_enable_q, global_gain_q);
      end else if (hit_select) begin
        if (add_offset_q) begin
          rdata_d = odd_fields;
        end else begin
          rdata_d = even_fields;
        end
      end
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_q <= {`DATA_W{1'b0}};
    end else begin
      rdata_q <= rdata_d;
    end
  end

endmodule // amp_gain_select_regs

`default_nettype wire

// ### bench/amp_gain_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module amp_gain_monitor #(
  parameter NUM_CH = 16
) (
  input wire logic                mclk,
  input wire logic                rst,
  input wire logic [7:0]          addr,
  input wire logic [15:0]         wdata,
  input wire logic                wr,
  input wire logic [2*NUM_CH-1:0] amp_gain_code_q,
  input wire logic [5*NUM_CH-1:0] amp_gain_db_q,
  input wire logic                per_channel_gain_enable_q,
  input wire logic                reserved_code_seen_q,
  input wire logic                add_offset_q
);
  // ****************************************************************
  // Gain path properties
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  wire gain_wr = wr && addr == 8'hd9;
  wire en = per_channel_gain_enable_q;
  // The quiet cycle after the write keeps a later write from blurring
  // which word the applied code should come from.
  a_odd_apply: assert property (
    gain_wr && add_offset_q && en && wdata[1:0] != 2'h3 ##1 !wr
    |=> ##1 amp_gain_code_q[3:2] == $past(wdata[1:0], 3))
    else $error("odd channel gain not applied");
  a_even_route: assert property (
    gain_wr && !add_offset_q && en |-> ##2 $stable(amp_gain_code_q[3:2]))
    else $error("odd channel moved on even write");
  a_code_to_db: assert property (
    amp_gain_db_q[79:75] == (amp_gain_code_q[31:30] == 2'h0 ? 5'h12 :
    amp_gain_code_q[31:30] == 2'h1 ? 5'h18 : 5'h0c))
    else $error("gain in dB does not match code");
  a_resv_hold: assert property (
    amp_gain_code_q[3:2] != 2'h3 && amp_gain_code_q[31:30] != 2'h3)
    else $error("reserved code applied");
  a_resv_flag: assert property (
    gain_wr && wdata[1:0] == 2'h3 |=> reserved_code_seen_q)
    else $error("reserved write not flagged");
  a_enable_gate: assert property (
    (!en)[*2] |-> amp_gain_code_q[31:30] == amp_gain_code_q[1:0])
    else $error("per channel gain used while disabled");
endmodule // amp_gain_monitor
bind amp_gain_select_regs amp_gain_monitor #(.NUM_CH(NUM_CH))
  amp_gain_monitor_i (
  .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
  .amp_gain_code_q(amp_gain_code_q), .amp_gain_db_q(amp_gain_db_q),
  .per_channel_gain_enable_q(per_channel_gain_enable_q),
  .reserved_code_seen_q(reserved_code_seen_q), .add_offset_q(add_offset_q));
`default_nettype wire

// ### bench/amp_gain_select_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module amp_gain_select_regs_tb;
  logic        mclk = 0, rst = 1, wr = 0, rd = 0;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  wire  [15:0] rdata;
  wire  [31:0] code;
  wire  [79:0] db;
  wire         en, off, flag;
  int          bad_count = 0, tests_run = 0, cyc = 0;
  amp_gain_select_regs amp_gain_select_regs_i (.mclk(mclk), .rst(rst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata),
    .amp_gain_code_q(code), .amp_gain_db_q(db),
    .per_channel_gain_enable_q(en), .add_offset_q(off),
    .reserved_code_seen_q(flag));
  // ****************************************************************
  // Bus tasks and checks
  // ****************************************************************
  initial forever #4 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 500) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic check(input string what, input logic [79:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 check("rdata", exp, rdata);
  endtask
  // Settle two edges so the applied outputs have caught up.
  task automatic chk_ch(input int ch, input logic [1:0] c);
    repeat (2) @(posedge mclk);
    #1 check("code", c, code[2*ch+:2]);
    check("db", c == 2'h0 ? 5'h12 : c == 2'h1 ? 5'h18 : 5'h0c, db[5*ch+:5]);
  endtask
  task automatic chk_odd(input logic [15:0] w);
    for (int i = 0; i < 8; i++) chk_ch(2 * i + 1, w[2*i+:2]);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    chk_odd(16'h0000);
    rd_reg(8'hd9, 16'h0000);
  endtask
  task automatic t_odd();
    wr_reg(8'h01, 16'h0001);
    wr_reg(8'hc4, 16'h8000);
    wr_reg(8'hd9, 16'h6186);
    rd_reg(8'hd9, 16'h6186);
    chk_odd(16'h6186);
    chk_ch(0, 2'h0);
  endtask
  task automatic t_resv();
    wr_reg(8'hd9, 16'h6187);
    rd_reg(8'hd9, 16'h6187);
    chk_odd(16'h6186);
    check("flag", 1'b1, flag);
  endtask
  task automatic t_status();
    rd_reg(8'h02, 16'h0007);
    rd_reg(8'h01, 16'h0001);
    rd_reg(8'hc4, 16'h8000);
    check("en", 1'b1, en);
    check("off", 1'b1, off);
    wr_reg(8'h02, 16'h0001);
    rd_reg(8'h02, 16'h0006);
    check("flag", 1'b0, flag);
  endtask
  task automatic t_even();
    wr_reg(8'h01, 16'h0000);
    wr_reg(8'hd9, 16'h5555);
    rd_reg(8'hd9, 16'h5555);
    check("off", 1'b0, off);
    chk_odd(16'h6186);
    chk_ch(14, 2'h1);
    rd_reg(8'h55, 16'h0000);
  endtask
  task automatic t_global();
    wr_reg(8'hc4, 16'h0002);
    rd_reg(8'hc4, 16'h0002);
    chk_ch(15, 2'h2);
    chk_ch(0, 2'h2);
    check("en", 1'b0, en);
    wr_reg(8'hc4, 16'h8000);
    chk_ch(15, 2'h1);
    chk_ch(0, 2'h1);
  endtask
  task automatic give_verdict();
    if (bad_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_odd();
    t_resv();
    t_status();
    t_even();
    t_global();
    give_verdict();
  end
endmodule // amp_gain_select_regs_tb
`default_nettype wire
